// ===== mc_status_pkg.sv
// Field positions, codes and reset values of the machine-check status layouts
package mc_status_pkg;

  localparam int STATUS_W = 64;

  // Architectural error code field, shared by both layouts
  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 15;

  // Fixed upper pattern of a compound bus-error code (bits 15:11)
  localparam int          BUS_PREFIX_LSB = 11;
  localparam logic [4:0]  BUS_CODE_PREFIX = 5'h01;
  localparam int          BUS_DETAIL_W   = 11;

  // Fixed upper pattern of a compound memory-hierarchy code (bits 15:8)
  localparam int          MEM_PREFIX_LSB = 8;
  localparam logic [7:0]  MEM_CODE_PREFIX = 8'h01;
  localparam int          MEM_DETAIL_W   = 8;

  // Bus-error layout model-specific bits
  localparam int BUS_ADDR_PARITY_BIT   = 16;
  localparam int BUS_RESP_HARD_BIT     = 17;
  localparam int BUS_RESP_PARITY_BIT   = 18;
  localparam int BUS_DATA_PARITY_BIT   = 19;
  localparam int BUS_INVALID_REQ_BIT   = 20;
  localparam int BUS_STROBE_SYNC_BIT   = 21;
  localparam int BUS_DATA_GLITCH_BIT   = 22;
  localparam int BUS_ADDR_GLITCH_BIT   = 23;

  // Memory-hierarchy layout model-specific fields
  localparam int MEM_TAG_ERR_LSB       = 16;
  localparam int MEM_DATA_ERR_LSB      = 18;
  localparam int MEM_THIRD_LEVEL_BIT   = 20;
  localparam int MEM_INVALID_REQ_BIT   = 21;
  localparam int MEM_COUNT_LSB         = 32;
  localparam int COUNT_W               = 8;

  // Reset values and the saturation value of the error count
  localparam logic [STATUS_W-1:0] STATUS_RESET = 64'h0000_0000_0000_0000;
  localparam logic [COUNT_W-1:0]  COUNT_RESET  = 8'h00;
  localparam logic [COUNT_W-1:0]  COUNT_MAX    = 8'hff;

  // Processor signature that uses the invalid-request bit of the bus layout (value arbitrary)
  localparam logic [31:0] INVALID_REQ_SIGNATURE = 32'h0000_0a5c;

  // Tag error encodings
  typedef enum logic [1:0] {
    TAG_NONE       = 2'b00,
    TAG_MISS_CLEAN = 2'b01,
    TAG_HIT_FAULT  = 2'b10,
    TAG_MISS_FAULT = 2'b11
  } tag_err_t;

  // Data error encodings
  typedef enum logic [1:0] {
    DATA_NONE         = 2'b00,
    DATA_SINGLE       = 2'b01,
    DATA_DOUBLE_CLEAN = 2'b10,
    DATA_DOUBLE_DIRTY = 2'b11
  } data_err_t;

endpackage

// ===== mc_status_logger.sv
// Machine-check bank status capture for bus and memory-hierarchy errors
// What this block does
// RULE1 - Bus error code in bits 15:0 is 0000 1PPT RRRR IILL.
// RULE2 - Bus layout bit 16 set on address parity error, else zero.
// RULE3 - Bus layout bit 17 set on response hardware failure.
// RULE4 - Bus layout bit 18 set on response parity error.
// RULE5 - Bus layout bit 19 set on controller-space or bus data parity error.
// RULE6 - Bus layout bit 20 flags invalid controller request on one signature only.
// RULE7 - Bits 21, 22, 23 flag strobe sync loss, data glitch, address glitch.
// RULE8 - Memory error code in bits 15:0 is 0000 0001 RRRR TTLL.
// RULE9 - Bits 17:16 hold the two-bit tag error kind.
// RULE10 - Bits 19:18 hold the two-bit data error kind.
// RULE11 - Bit 20 is one for third-level cache, zero for second-level.
// RULE12 - Bit 21 set for write-back access to controller space, else cleared.
// RULE13 - Bits 39:32 count errors: zero first, then increment, saturate at 255.
// RULE14 - All fields of a layout update together in one cycle.
module mc_status_logger
  import mc_status_pkg::*;
#(
  parameter logic [31:0] CPU_SIGNATURE = 32'h0000_0001  // Value arbitrary
) (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  // Bus error event and its details
  input  wire logic                    bus_err_valid,
  input  wire logic [BUS_DETAIL_W-1:0] bus_err_detail,
  input  wire logic                    bus_addr_parity,
  input  wire logic                    bus_resp_hard_fail,
  input  wire logic                    bus_resp_parity,
  input  wire logic                    bus_data_parity,
  input  wire logic                    bus_invalid_req,
  input  wire logic                    strobe_sync_lost,
  input  wire logic                    data_strobe_glitch,
  input  wire logic                    addr_strobe_glitch,
  // Memory hierarchy error event and its details
  input  wire logic                    mem_err_valid,
  input  wire logic [MEM_DETAIL_W-1:0] mem_err_detail,
  input  wire logic [1:0]              mem_tag_err,
  input  wire logic [1:0]              mem_data_err,
  input  wire logic                    mem_third_level,
  input  wire logic                    mem_invalid_req,
  // Status words and update pulses
  output logic      [STATUS_W-1:0]     bus_status,
  output logic      [STATUS_W-1:0]     mem_status,
  output logic                         bus_logged,
  output logic                         mem_logged
);

  logic [COUNT_W-1:0]  err_total;
  logic [STATUS_W-1:0] next_bus_status;
  logic [STATUS_W-1:0] next_mem_status;
  logic [COUNT_W-1:0]  next_err_total;
  logic                next_bus_logged;
  logic                next_mem_logged;

  // Build the bus-layout word from one error event
  function automatic logic [STATUS_W-1:0] bus_word(
    input logic [BUS_DETAIL_W-1:0] detail,
    input logic                    addr_par,
    input logic                    hard,
    input logic                    resp_par,
    input logic                    data_par,
    input logic                    inv_req,
    input logic                    sync_lost,
    input logic                    d_glitch,
    input logic                    a_glitch
  );
    logic [STATUS_W-1:0] w;
    w = STATUS_RESET;
    // RULE1 compound bus code
    w[CODE_MSB:BUS_PREFIX_LSB]   = BUS_CODE_PREFIX;
    w[BUS_PREFIX_LSB-1:CODE_LSB] = detail;
    // RULE2 address parity
    w[BUS_ADDR_PARITY_BIT] = addr_par;
    // RULE3 response hard failure
    w[BUS_RESP_HARD_BIT] = hard;
    // RULE4 response parity
    w[BUS_RESP_PARITY_BIT] = resp_par;
    // RULE5 data parity
    w[BUS_DATA_PARITY_BIT] = data_par;
    // RULE6 revision-gated invalid request, reserved zero elsewhere
    w[BUS_INVALID_REQ_BIT] = (CPU_SIGNATURE == INVALID_REQ_SIGNATURE) && inv_req;
    // RULE7 pad strobe faults
    w[BUS_STROBE_SYNC_BIT] = sync_lost;
    w[BUS_DATA_GLITCH_BIT] = d_glitch;
    w[BUS_ADDR_GLITCH_BIT] = a_glitch;
    return w;
  endfunction

  // Build the memory-layout word from one error event
  function automatic logic [STATUS_W-1:0] mem_word(
    input logic [MEM_DETAIL_W-1:0] detail,
    input logic [1:0]              tag_err,
    input logic [1:0]              data_err,
    input logic                    third,
    input logic                    inv_req,
    input logic [COUNT_W-1:0]      count
  );
    logic [STATUS_W-1:0] w;
    w = STATUS_RESET;
    // RULE8 compound memory code
    w[CODE_MSB:MEM_PREFIX_LSB]   = MEM_CODE_PREFIX;
    w[MEM_PREFIX_LSB-1:CODE_LSB] = detail;
    // RULE9 tag error kind
    w[MEM_TAG_ERR_LSB+1:MEM_TAG_ERR_LSB] = tag_err;
    // RULE10 data error kind
    w[MEM_DATA_ERR_LSB+1:MEM_DATA_ERR_LSB] = data_err;
    // RULE11 cache level
    w[MEM_THIRD_LEVEL_BIT] = third;
    // RULE12 invalid controller-space request
    w[MEM_INVALID_REQ_BIT] = inv_req;
    // RULE13 count as it stood before this error
    w[MEM_COUNT_LSB+COUNT_W-1:MEM_COUNT_LSB] = count;
    return w;
  endfunction

  // Next status words, pulses and error count
  always_comb begin
    // Default: both words hold, pulses follow the event inputs
    next_bus_status = bus_status;
    next_mem_status = mem_status;
    next_err_total  = err_total;
    next_bus_logged = bus_err_valid;
    next_mem_logged = mem_err_valid;
    // RULE14 whole word captured at once
    if (bus_err_valid) begin
      next_bus_status = bus_word(bus_err_detail, bus_addr_parity, bus_resp_hard_fail, bus_resp_parity,
                                 bus_data_parity, bus_invalid_req, strobe_sync_lost,
                                 data_strobe_glitch, addr_strobe_glitch);
    end
    if (mem_err_valid) begin
      next_mem_status = mem_word(mem_err_detail, mem_tag_err, mem_data_err, mem_third_level,
                                 mem_invalid_req, err_total);
      // RULE13 saturating increment
      if (err_total != COUNT_MAX) begin
        next_err_total = err_total + 8'h01;
      end
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_status <= STATUS_RESET;
      mem_status <= STATUS_RESET;
      err_total  <= COUNT_RESET;
      bus_logged <= 1'b0;
      mem_logged <= 1'b0;
    end else begin
      bus_status <= next_bus_status;
      mem_status <= next_mem_status;
      err_total  <= next_err_total;
      bus_logged <= next_bus_logged;
      mem_logged <= next_mem_logged;
    end
  end

  // Helper: a memory error has been seen since reset
  logic mem_seen;
  logic next_mem_seen;
  always_comb begin
    next_mem_seen = mem_seen || mem_err_valid;
  end
  // Register the helper flag
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_seen <= 1'b0;
    end else begin
      mem_seen <= next_mem_seen;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Bus-layout word checks
  property p_bus_code;
    bus_err_valid |=> bus_status[CODE_MSB:BUS_PREFIX_LSB] == BUS_CODE_PREFIX
                      && bus_status[BUS_PREFIX_LSB-1:CODE_LSB] == $past(bus_err_detail) && bus_logged;
  endproperty
  a_bus_code: assert property (p_bus_code) else $error("bus error code wrong"); // RULE1

  property p_addr_parity;
    bus_err_valid |=> bus_status[BUS_ADDR_PARITY_BIT] == $past(bus_addr_parity);
  endproperty
  a_addr_parity: assert property (p_addr_parity) else $error("address parity bit wrong"); // RULE2

  property p_resp_bits;
    bus_err_valid |=> bus_status[BUS_RESP_HARD_BIT] == $past(bus_resp_hard_fail)
                      && bus_status[BUS_RESP_PARITY_BIT] == $past(bus_resp_parity);
  endproperty
  a_resp_bits: assert property (p_resp_bits) else $error("response bits wrong"); // RULE3

  property p_resp_parity;
    bus_err_valid && bus_resp_parity |=> bus_status[BUS_RESP_PARITY_BIT] ##1 bus_status[BUS_RESP_PARITY_BIT] || bus_logged;
  endproperty
  a_resp_parity: assert property (p_resp_parity) else $error("response parity lost"); // RULE4

  property p_data_parity;
    bus_err_valid |=> bus_status[BUS_DATA_PARITY_BIT] == $past(bus_data_parity);
  endproperty
  a_data_parity: assert property (p_data_parity) else $error("data parity bit wrong"); // RULE5

  property p_invalid_bus;
    bus_err_valid |=> bus_status[BUS_INVALID_REQ_BIT] ==
                      ((CPU_SIGNATURE == INVALID_REQ_SIGNATURE) && $past(bus_invalid_req));
  endproperty
  a_invalid_bus: assert property (p_invalid_bus) else $error("gated invalid request bit wrong"); // RULE6

  property p_strobe_bits;
    bus_err_valid |=> bus_status[BUS_ADDR_GLITCH_BIT:BUS_STROBE_SYNC_BIT] ==
                      {$past(addr_strobe_glitch), $past(data_strobe_glitch), $past(strobe_sync_lost)};
  endproperty
  a_strobe_bits: assert property (p_strobe_bits) else $error("strobe fault bits wrong"); // RULE7

  property p_bus_reserved;
    bus_err_valid |=> bus_status[STATUS_W-1:BUS_ADDR_GLITCH_BIT+1] == '0;
  endproperty
  a_bus_reserved: assert property (p_bus_reserved) else $error("bus reserved bits not zero"); // RULE14

  // Memory-layout word checks
  property p_mem_code;
    mem_err_valid |=> mem_status[CODE_MSB:MEM_PREFIX_LSB] == MEM_CODE_PREFIX
                      && mem_status[MEM_PREFIX_LSB-1:CODE_LSB] == $past(mem_err_detail) && mem_logged;
  endproperty
  a_mem_code: assert property (p_mem_code) else $error("memory error code wrong"); // RULE8

  property p_tag_data;
    mem_err_valid |=> mem_status[MEM_TAG_ERR_LSB+1:MEM_TAG_ERR_LSB] == $past(mem_tag_err)
                      && mem_status[MEM_DATA_ERR_LSB+1:MEM_DATA_ERR_LSB] == $past(mem_data_err);
  endproperty
  a_tag_data: assert property (p_tag_data) else $error("tag or data field wrong"); // RULE9

  property p_tag_miss_clean;
    mem_err_valid && mem_tag_err == TAG_MISS_CLEAN |=> mem_status[MEM_TAG_ERR_LSB+1:MEM_TAG_ERR_LSB] == 2'b01;
  endproperty
  a_tag_miss_clean: assert property (p_tag_miss_clean) else $error("tag miss clean code wrong"); // RULE9

  property p_tag_hit_fault;
    mem_err_valid && mem_tag_err == TAG_HIT_FAULT |=> mem_status[MEM_TAG_ERR_LSB+1:MEM_TAG_ERR_LSB] == 2'b10;
  endproperty
  a_tag_hit_fault: assert property (p_tag_hit_fault) else $error("tag hit fault code wrong"); // RULE9

  property p_data_kind;
    mem_err_valid && mem_data_err == DATA_DOUBLE_DIRTY |=> mem_status[MEM_DATA_ERR_LSB+1:MEM_DATA_ERR_LSB] == 2'b11;
  endproperty
  a_data_kind: assert property (p_data_kind) else $error("data error kind wrong"); // RULE10

  property p_data_single;
    mem_err_valid && mem_data_err == DATA_SINGLE |=> mem_status[MEM_DATA_ERR_LSB+1:MEM_DATA_ERR_LSB] == 2'b01;
  endproperty
  a_data_single: assert property (p_data_single) else $error("single-bit data code wrong"); // RULE10

  property p_level_inv;
    mem_err_valid |=> mem_status[MEM_THIRD_LEVEL_BIT] == $past(mem_third_level)
                      && mem_status[MEM_INVALID_REQ_BIT] == $past(mem_invalid_req);
  endproperty
  a_level_inv: assert property (p_level_inv) else $error("level or invalid bit wrong"); // RULE11

  property p_mem_invalid_clear;
    mem_err_valid && !mem_invalid_req |=> !mem_status[MEM_INVALID_REQ_BIT];
  endproperty
  a_mem_invalid_clear: assert property (p_mem_invalid_clear) else $error("invalid bit not cleared"); // RULE12

  property p_first_count;
    mem_err_valid && !mem_seen |=> mem_status[MEM_COUNT_LSB+COUNT_W-1:MEM_COUNT_LSB] == 8'h00;
  endproperty
  a_first_count: assert property (p_first_count) else $error("first count not zero"); // RULE13

  property p_count_step;
    mem_err_valid |=> err_total == (($past(err_total) == COUNT_MAX) ? COUNT_MAX : 8'($past(err_total) + 8'h01));
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong"); // RULE13

  property p_count_saturate;
    mem_err_valid && err_total == COUNT_MAX |=> err_total == COUNT_MAX
                      && mem_status[MEM_COUNT_LSB+COUNT_W-1:MEM_COUNT_LSB] == COUNT_MAX;
  endproperty
  a_count_saturate: assert property (p_count_saturate) else $error("count left saturation"); // RULE13

  property p_count_hold;
    !mem_err_valid |=> $stable(err_total);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved without memory error"); // RULE13

  property p_mem_reserved;
    mem_err_valid |=> mem_status[MEM_COUNT_LSB-1:MEM_INVALID_REQ_BIT+1] == '0
                      && mem_status[STATUS_W-1:MEM_COUNT_LSB+COUNT_W] == '0;
  endproperty
  a_mem_reserved: assert property (p_mem_reserved) else $error("memory reserved bits not zero"); // RULE14

  property p_hold;
    !bus_err_valid && !mem_err_valid |=> $stable(bus_status) && $stable(mem_status) && !bus_logged && !mem_logged;
  endproperty
  a_hold: assert property (p_hold) else $error("status changed without event"); // RULE14

  property p_bus_only;
    bus_err_valid && !mem_err_valid |=> $stable(mem_status) && !mem_logged;
  endproperty
  a_bus_only: assert property (p_bus_only) else $error("bus event touched memory word"); // RULE14

  property p_mem_only;
    mem_err_valid && !bus_err_valid |=> $stable(bus_status) && !bus_logged;
  endproperty
  a_mem_only: assert property (p_mem_only) else $error("memory event touched bus word"); // RULE14

  // Coverage of the main scenarios
  c_bus_event:   cover property (bus_err_valid ##1 bus_logged);
  c_mem_event:   cover property (mem_err_valid ##1 mem_logged);
  c_both:        cover property (bus_err_valid && mem_err_valid);
  c_saturated:   cover property (mem_err_valid && err_total == COUNT_MAX);
  c_invalid_req: cover property (bus_err_valid && bus_invalid_req);

endmodule

// ===== machine_check_error_logging_tb_top.sv
// Self-checking bench for the machine-check status logger
module machine_check_error_logging_tb_top
  import mc_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, act, exp); end end

  logic                    ref_clk, resetn, bus_err_valid, mem_err_valid;
  logic [BUS_DETAIL_W-1:0] bus_err_detail;
  logic                    bus_addr_parity, bus_resp_hard_fail, bus_resp_parity, bus_data_parity;
  logic                    bus_invalid_req, strobe_sync_lost, data_strobe_glitch, addr_strobe_glitch;
  logic [MEM_DETAIL_W-1:0] mem_err_detail;
  logic [1:0]              mem_tag_err, mem_data_err;
  logic                    mem_third_level, mem_invalid_req;
  logic [STATUS_W-1:0]     bus_status, mem_status, bus_status_sig, mem_status_sig;
  logic                    bus_logged, mem_logged, bus_logged_sig, mem_logged_sig;
  int                      errors, checks_done, cycles, mem_n;

  // Default signature and the one that enables the invalid-request bit
  mc_status_logger i_mc_status_logger (
    .ref_clk(ref_clk), .resetn(resetn), .bus_err_valid(bus_err_valid), .bus_err_detail(bus_err_detail),
    .bus_addr_parity(bus_addr_parity), .bus_resp_hard_fail(bus_resp_hard_fail),
    .bus_resp_parity(bus_resp_parity), .bus_data_parity(bus_data_parity), .bus_invalid_req(bus_invalid_req),
    .strobe_sync_lost(strobe_sync_lost), .data_strobe_glitch(data_strobe_glitch),
    .addr_strobe_glitch(addr_strobe_glitch), .mem_err_valid(mem_err_valid), .mem_err_detail(mem_err_detail),
    .mem_tag_err(mem_tag_err), .mem_data_err(mem_data_err), .mem_third_level(mem_third_level),
    .mem_invalid_req(mem_invalid_req), .bus_status(bus_status), .mem_status(mem_status),
    .bus_logged(bus_logged), .mem_logged(mem_logged));
  mc_status_logger #(.CPU_SIGNATURE(INVALID_REQ_SIGNATURE)) i_mc_status_logger_sig (
    .ref_clk(ref_clk), .resetn(resetn), .bus_err_valid(bus_err_valid), .bus_err_detail(bus_err_detail),
    .bus_addr_parity(bus_addr_parity), .bus_resp_hard_fail(bus_resp_hard_fail),
    .bus_resp_parity(bus_resp_parity), .bus_data_parity(bus_data_parity), .bus_invalid_req(bus_invalid_req),
    .strobe_sync_lost(strobe_sync_lost), .data_strobe_glitch(data_strobe_glitch),
    .addr_strobe_glitch(addr_strobe_glitch), .mem_err_valid(mem_err_valid), .mem_err_detail(mem_err_detail),
    .mem_tag_err(mem_tag_err), .mem_data_err(mem_data_err), .mem_third_level(mem_third_level),
    .mem_invalid_req(mem_invalid_req), .bus_status(bus_status_sig), .mem_status(mem_status_sig),
    .bus_logged(bus_logged_sig), .mem_logged(mem_logged_sig));

  // Clock of 25 ns period
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Cycle ceiling against hangs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_sim();
    end
  end

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Expected bus word from detail and flags
  function automatic logic [STATUS_W-1:0] bus_word(input logic [10:0] d, input logic [7:0] f);
    return {40'h00_0000_0000, f, BUS_CODE_PREFIX, d};
  endfunction

  // Expected memory word from the inputs and a count
  function automatic logic [STATUS_W-1:0] mem_word(input logic [7:0] c);
    return {24'h00_0000, c, 10'h000, mem_invalid_req, mem_third_level, mem_data_err, mem_tag_err,
            MEM_CODE_PREFIX, mem_err_detail};
  endfunction

  // Bus events held for n cycles, each high cycle an event
  task automatic bus_run(input logic [10:0] d, input logic [7:0] f, input int n);
    @(posedge ref_clk);
    bus_err_valid <= 1'b1;
    bus_err_detail <= d;
    {addr_strobe_glitch, data_strobe_glitch, strobe_sync_lost, bus_invalid_req,
     bus_data_parity, bus_resp_parity, bus_resp_hard_fail, bus_addr_parity} <= f;
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk);
      if (k == n - 1) bus_err_valid <= 1'b0;
      @(negedge ref_clk);
      `CHK(bus_logged, 1'b1)
      `CHK(bus_logged_sig, 1'b1)
      `CHK(bus_status, bus_word(d, f & 8'hef))
      `CHK(bus_status_sig, bus_word(d, f))
    end
    @(negedge ref_clk);
    `CHK(bus_logged, 1'b0)
    `CHK(bus_logged_sig, 1'b0)
    `CHK(bus_status, bus_word(d, f & 8'hef))
    `CHK(bus_status_sig, bus_word(d, f))
  endtask

  // Memory events held for n cycles, count expected per event
  task automatic mem_run(input logic [7:0] d, input logic [1:0] t, dt, input logic lvl, inv, input int n);
    @(posedge ref_clk);
    mem_err_valid <= 1'b1;
    {mem_err_detail, mem_tag_err, mem_data_err, mem_third_level, mem_invalid_req} <= {d, t, dt, lvl, inv};
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk);
      if (k == n - 1) mem_err_valid <= 1'b0;
      @(negedge ref_clk);
      `CHK(mem_logged, 1'b1)
      `CHK(mem_logged_sig, 1'b1)
      `CHK(mem_status, mem_word((mem_n > 255) ? 8'hff : 8'(mem_n)))
      `CHK(mem_status_sig, mem_word((mem_n > 255) ? 8'hff : 8'(mem_n)))
      mem_n++;
    end
    @(negedge ref_clk);
    `CHK(mem_logged, 1'b0)
    `CHK(mem_logged_sig, 1'b0)
    `CHK(mem_status, mem_word((mem_n > 256) ? 8'hff : 8'(mem_n - 1)))
  endtask

  // Main sequence
  initial begin
    {bus_err_valid, mem_err_valid, bus_err_detail, mem_err_detail, mem_tag_err, mem_data_err} = '0;
    {bus_addr_parity, bus_resp_hard_fail, bus_resp_parity, bus_data_parity} = 4'h0;
    {bus_invalid_req, strobe_sync_lost, data_strobe_glitch, addr_strobe_glitch} = 4'h0;
    {mem_third_level, mem_invalid_req, errors, checks_done, cycles, mem_n} = '0;
    resetn = 1'b0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    // Each flag alone, then all, then none overwriting
    for (int i = 0; i < 8; i++) bus_run(11'(i * 291 + 5), 8'(1 << i), 1);
    bus_run(11'h7ff, 8'hff, 2);
    bus_run(11'h000, 8'h00, 1);
    // Every tag and data code, both levels
    for (int i = 0; i < 16; i++) mem_run(8'(i * 17), 2'(i >> 2), 2'(i), i[0], i[1], 1);
    // Independent layouts in the same cycles
    fork
      bus_run(11'h2a5, 8'h5a, 3);
      mem_run(8'hc3, 2'h3, 2'h2, 1'b1, 1'b0, 3);
    join
    // Back-to-back events past saturation
    mem_run(8'h3c, 2'h1, 2'h3, 1'b0, 1'b1, 250);
    // Reset in mid-run restarts the count
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(mem_status, 64'h0000_0000_0000_0000)
    `CHK(bus_status, 64'h0000_0000_0000_0000)
    `CHK(bus_logged, 1'b0)
    `CHK(mem_logged, 1'b0)
    @(posedge ref_clk);
    resetn <= 1'b1;
    mem_n = 0;
    mem_run(8'h81, 2'h2, 2'h1, 1'b1, 1'b1, 2);
    end_sim();
  end

endmodule
